// File: src/cps_pkg.sv
// Package with states, acknowledge codes and timing constants of the power state control.
package cps_pkg;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_STOP_GRANT = 3'b001,
      ST_SLEEP = 3'b010,
      ST_DEEP_SLEEP = 3'b011,
      ST_SMM = 3'b100,
      ST_HALT = 3'b101
   } cps_state_type;
   typedef enum logic [1:0] {
      ACK_NONE = 2'b00,
      ACK_STOP_GRANT = 2'b01,
      ACK_SMI = 2'b10
   } cps_ack_type;
   localparam int SYNC_STAGES = 2;
   localparam int CLK_PERIOD_NS = 10;
   localparam int OUT_RELEASE_CLOCKS = 2;
   localparam int ACK_PULSE_CYCLES = 1;
   localparam logic [7:0] TRIP_TEMP_C = 8'h78;
   localparam int CLK_UNIT_W = 4;
   localparam int UNIT_BUS = 0;
   localparam int UNIT_LIC = 1;
   localparam int UNIT_CORE = 2;
   localparam int UNIT_EXEC = 3;
   localparam logic [3:0] GATE_ALL_ON = 4'hF;
endpackage

// File: src/cps_sync.sv
// Two-flop synchroniser for one asynchronous active-low request.
`timescale 1ns/1ns
module cps_sync (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic async_n,
   output logic sync_n
);
   import cps_pkg::*;
   logic meta_q;
   logic sync_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= async_n;
         sync_q <= meta_q;
      end
   end
   assign sync_n = sync_q;
endmodule

// File: src/cps_clock_gate_map.sv
// Maps the power state to per-unit internal clock enables.
`timescale 1ns/1ns
module cps_clock_gate_map (
   input cps_pkg::cps_state_type state,
   output logic [cps_pkg::CLK_UNIT_W-1:0] unit_en,
   output logic pll_en
);
   import cps_pkg::*;
   logic [CLK_UNIT_W-1:0] stop_grant_en;
   assign stop_grant_en = (CLK_UNIT_W'(1) << UNIT_BUS) | (CLK_UNIT_W'(1) << UNIT_LIC);
   // The loop keeps running in every state so that wake-up needs no relock.
   assign pll_en = 1'b1;
   assign unit_en = (state == ST_STOP_GRANT) ? stop_grant_en :
                    (state == ST_SLEEP || state == ST_DEEP_SLEEP || state == ST_HALT) ?
                    '0 : GATE_ALL_ON[CLK_UNIT_W-1:0];
endmodule

// File: src/cps_power_ctrl.sv
// Power state sequencer: stop-clock, sleep, deep sleep, management interrupt and thermal trip.
//
// Notes on behaviour
// - Asserted sleep request moves the processor from Stop-Grant into Sleep.
// - In Sleep all unit clocks stop; only the PLL keeps running.
// - Sleep ignores snoops and interrupts; wakes on reset or sleep release; clock loss enters Deep Sleep.
// - Sleep release returns to Stop-Grant, restarting bus unit and interrupt controller clocks.
// - Management interrupt is asynchronous and synchronised before use.
// - Accepting the interrupt saves execution state and enters management mode.
// - After entering management mode, an acknowledge is issued, then handler runs, unless stop-clock is seen in the first management mode cycle.
// - Interrupt asserted while reset releases puts all outputs in high impedance.
// - Stop-clock assertion moves running processor into Stop-Grant.
// - Entering Stop-Grant from Run or management mode issues a Stop-Grant acknowledge on the bus; return from Sleep issues none.
// - Stop-Grant keeps only bus unit and interrupt controller clocks.
// - Stop-Grant keeps snooping and servicing interrupts.
// - Stop-clock release restarts all clocks and resumes execution.
// - Stop-clock is asynchronous and never touches the external bus clock.
// - Temperature above 120 C halts execution and asserts the trip output.
// - Reset returns to known state, invalidates caches, releases outputs in the cycle reset goes low.
`timescale 1ns/1ns
module cps_power_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clock_stop_request_n,
   input wire logic sleep_request_n,
   input wire logic deep_sleep_request_n,
   input wire logic sys_mgmt_irq_n,
   input wire logic bus_clock_lost,
   input wire logic [7:0] junction_temp_c,
   input wire logic snoop_req,
   input wire logic intr_req,
   input wire logic smm_resume,
   output cps_pkg::cps_state_type power_state,
   output logic [cps_pkg::CLK_UNIT_W-1:0] unit_clk_en,
   output logic pll_en,
   output logic bus_clk_en,
   output cps_pkg::cps_ack_type ack_code,
   output logic ack_valid,
   output logic ack_oe,
   output logic save_state,
   output logic system_management_mode,
   output logic handler_start,
   output logic exec_run,
   output logic snoop_ack,
   output logic intr_ack,
   output logic cache_invalidate,
   output logic thermal_trip_out_n,
   output logic thermal_trip_oe,
   output logic outputs_oe
);
   import cps_pkg::*;

   logic stop_sync_n;
   logic sleep_sync_n;
   logic deep_sync_n;
   logic smi_s_n;
   cps_state_type state_q;
   cps_state_type state_d;
   cps_state_type resume_q;
   logic rst_q;
   logic tristate_now;
   logic tristate_q;
   logic trip_q;
   logic smi_pend_q;
   logic ack_valid_q;
   cps_ack_type ack_code_q;
   logic save_q;
   logic hstart_q;
   logic smm_ack_done_q;
   logic cache_inv_q;
   logic over_temp;
   logic smi_edge;
   logic smi_prev_q;
   logic enter_sg;
   logic enter_smm;

   // Separate synchronisers keep each request's metastability apart.
   cps_sync u_sync_stop (.ref_clk(ref_clk), .rst(rst), .async_n(clock_stop_request_n),
                         .sync_n(stop_sync_n));
   cps_sync u_sync_sleep (.ref_clk(ref_clk), .rst(rst), .async_n(sleep_request_n),
                          .sync_n(sleep_sync_n));
   cps_sync u_sync_deep (.ref_clk(ref_clk), .rst(rst), .async_n(deep_sleep_request_n),
                         .sync_n(deep_sync_n));
   // This one is never reset, so its level is already valid where reset ends.
   cps_sync u_sync_smi (.ref_clk(ref_clk), .rst(1'b0), .async_n(sys_mgmt_irq_n),
                        .sync_n(smi_s_n));

   cps_clock_gate_map u_gate (.state(state_q), .unit_en(unit_clk_en), .pll_en(pll_en));

   assign over_temp = junction_temp_c > TRIP_TEMP_C;
   assign smi_edge = !smi_s_n && smi_prev_q;
   assign enter_sg = state_q == ST_RUN && !stop_sync_n;
   assign enter_smm = state_q == ST_RUN && state_d == ST_SMM;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (!stop_sync_n) begin
               state_d = ST_STOP_GRANT;
            end else if (smi_pend_q) begin
               state_d = ST_SMM;
            end
         end
         ST_STOP_GRANT: begin
            if (!sleep_sync_n) begin
               state_d = ST_SLEEP;
            end else if (stop_sync_n) begin
               state_d = resume_q;
            end
         end
         ST_SLEEP: begin
            if (sleep_sync_n) begin
               state_d = ST_STOP_GRANT;
            end else if (!deep_sync_n || bus_clock_lost) begin
               state_d = ST_DEEP_SLEEP;
            end
         end
         ST_DEEP_SLEEP: begin
            if (deep_sync_n && !bus_clock_lost) begin
               state_d = ST_SLEEP;
            end
         end
         ST_SMM: begin
            if (!stop_sync_n) begin
               state_d = ST_STOP_GRANT;
            end else if (smm_resume && smm_ack_done_q) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_HALT;
         end
      endcase
      if (trip_q || over_temp) begin
         state_d = ST_HALT;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= ST_RUN;
         resume_q <= ST_RUN;
      end else begin
         state_q <= state_d;
         if (enter_sg) begin
            resume_q <= ST_RUN;
         end else if (state_q == ST_SMM && state_d == ST_STOP_GRANT) begin
            resume_q <= ST_SMM;
         end
      end
   end

   // The interrupt is latched so one request is never lost while held off by Sleep.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         smi_prev_q <= 1'b1;
         smi_pend_q <= 1'b0;
      end else begin
         smi_prev_q <= smi_s_n;
         if (smi_edge) begin
            smi_pend_q <= 1'b1;
         end else if (enter_smm) begin
            smi_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_valid_q <= 1'b0;
         ack_code_q <= ACK_NONE;
         save_q <= 1'b0;
         hstart_q <= 1'b0;
         smm_ack_done_q <= 1'b0;
      end else begin
         ack_valid_q <= 1'b0;
         ack_code_q <= ACK_NONE;
         save_q <= enter_smm;
         hstart_q <= 1'b0;
         if (state_q != ST_STOP_GRANT && state_d == ST_STOP_GRANT && state_q != ST_SLEEP) begin
            ack_valid_q <= 1'b1;
            ack_code_q <= ACK_STOP_GRANT;
         end else if (save_q) begin
            ack_valid_q <= 1'b1;
            ack_code_q <= ACK_SMI;
         end
         if (ack_valid_q && ack_code_q == ACK_SMI) begin
            hstart_q <= 1'b1;
            smm_ack_done_q <= 1'b1;
         end else if (state_q != ST_SMM) begin
            smm_ack_done_q <= 1'b0;
         end
      end
   end

   // The trip is sticky: only reset clears it, since the part may still be too hot.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trip_q <= 1'b0;
      end else if (over_temp) begin
         trip_q <= 1'b1;
      end
   end

   // Interrupt level is caught at the edge where reset goes away.
   always_ff @(posedge ref_clk) begin
      rst_q <= rst;
      if (rst) begin
         cache_inv_q <= 1'b1;
      end else begin
         cache_inv_q <= 1'b0;
      end
      if (rst) begin
         tristate_q <= 1'b0;
      end else if (rst_q && !smi_s_n) begin
         tristate_q <= 1'b1;
      end
   end

   assign power_state = state_q;
   assign bus_clk_en = 1'b1;
   assign ack_valid = ack_valid_q;
   assign ack_code = ack_code_q;
   assign ack_oe = outputs_oe;
   assign save_state = save_q;
   assign system_management_mode = state_q == ST_SMM;
   assign handler_start = hstart_q;
   assign exec_run = (state_q == ST_RUN || state_q == ST_SMM) && !trip_q;
   assign snoop_ack = state_q == ST_STOP_GRANT && snoop_req;
   assign intr_ack = (state_q == ST_STOP_GRANT || state_q == ST_RUN) && intr_req;
   assign cache_invalidate = cache_inv_q;
   assign thermal_trip_out_n = !trip_q;
   // Outputs go quiet in the very cycle that reset ends, not one cycle after it.
   assign tristate_now = rst_q && !smi_s_n;
   assign outputs_oe = !rst && !tristate_q && !tristate_now;
   assign thermal_trip_oe = outputs_oe;

   chk_sleep_entry: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_STOP_GRANT && !sleep_sync_n && !over_temp && !trip_q |=> state_q == ST_SLEEP)
      else $error("sleep request did not enter sleep");
   chk_sleep_clocks: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_SLEEP |-> unit_clk_en == '0 && pll_en)
      else $error("clocks running in sleep");
   chk_sleep_deaf: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_SLEEP |-> !snoop_ack && !intr_ack)
      else $error("sleep answered a snoop or interrupt");
   chk_sleep_exit: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_SLEEP && sleep_sync_n && !over_temp && !trip_q |=> state_q == ST_STOP_GRANT)
      else $error("sleep release did not return to stop grant");
   chk_deep_entry: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_SLEEP && !sleep_sync_n && !deep_sync_n && !over_temp && !trip_q
      |=> state_q == ST_DEEP_SLEEP)
      else $error("deep sleep request did not enter deep sleep");
   chk_deep_clocks: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_DEEP_SLEEP |-> unit_clk_en == '0)
      else $error("clocks running in deep sleep");
   chk_clock_loss: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_SLEEP && !sleep_sync_n && bus_clock_lost && !over_temp && !trip_q
      |=> state_q == ST_DEEP_SLEEP)
      else $error("bus clock loss ignored in sleep");
   sequence sg_entry_seq;
      state_q == ST_RUN && !stop_sync_n && !over_temp && !trip_q;
   endsequence
   chk_sg_ack: assert property (@(posedge ref_clk) disable iff (rst)
      sg_entry_seq |=> ack_valid && ack_code == ACK_STOP_GRANT && state_q == ST_STOP_GRANT)
      else $error("stop grant acknowledge missing");
   chk_sg_clocks: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_STOP_GRANT |-> unit_clk_en[UNIT_BUS] && unit_clk_en[UNIT_LIC]
      && !unit_clk_en[UNIT_CORE])
      else $error("stop grant clock gating wrong");
   chk_sg_listen: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_STOP_GRANT |-> snoop_ack == snoop_req && intr_ack == intr_req)
      else $error("stop grant stopped snooping or servicing");
   chk_sg_resume: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_STOP_GRANT && stop_sync_n && sleep_sync_n && resume_q == ST_RUN && !over_temp
      && !trip_q |=> state_q == ST_RUN && exec_run && unit_clk_en == GATE_ALL_ON)
      else $error("stop clock release did not resume");
   chk_smi_save: assert property (@(posedge ref_clk) disable iff (rst)
      enter_smm |=> save_state && system_management_mode)
      else $error("management mode entry did not save state");
   chk_stop_sync: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(stop_sync_n) |-> $past(clock_stop_request_n, 2) == 1'b0)
      else $error("stop request acted on before two flops");
   chk_smi_sync: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(smi_s_n) |-> $past(sys_mgmt_irq_n, 2) == 1'b0)
      else $error("management interrupt used before two flops");
   chk_irq_tristate: assert property (@(posedge ref_clk) disable iff (rst)
      rst_q && !smi_s_n |-> !outputs_oe ##1 !outputs_oe)
      else $error("outputs driven after interrupt at reset release");
   sequence smi_enter_seq;
      enter_smm && !over_temp && !trip_q;
   endsequence
   chk_smi_order: assert property (@(posedge ref_clk) disable iff (rst)
      smi_enter_seq ##1 (state_q == ST_SMM && stop_sync_n && !over_temp && !trip_q)
      |-> ##1 (ack_valid && ack_code == ACK_SMI) ##1 handler_start)
      else $error("management acknowledge order wrong");
   chk_trip_halt: assert property (@(posedge ref_clk) disable iff (rst)
      over_temp |=> !thermal_trip_out_n && !exec_run && state_q == ST_HALT)
      else $error("thermal trip not signalled");
   chk_reset_release: assert property (@(posedge ref_clk)
      rst |-> !outputs_oe)
      else $error("outputs driven during reset");
   chk_reset_inval: assert property (@(posedge ref_clk)
      rst |=> cache_invalidate)
      else $error("caches not invalidated on reset");
endmodule

// File: dv/cps_platform_model.sv
// Platform model that drives the active-low power management requests.
`timescale 1ns/1ns
module cps_platform_model (
   input wire logic ref_clk,
   input wire logic stop_want,
   input wire logic sleep_want,
   input wire logic deep_want,
   input wire logic smi_want,
   output logic clock_stop_request_n,
   output logic sleep_request_n,
   output logic deep_sleep_request_n,
   output logic sys_mgmt_irq_n
);
   initial begin
      clock_stop_request_n = 1'b1;
      sleep_request_n = 1'b1;
      deep_sleep_request_n = 1'b1;
      sys_mgmt_irq_n = 1'b1;
   end
   // Sleep is only offered under stop-clock and deep sleep only under sleep.
   // A sloppy bench therefore cannot skip a state by accident.
   always @(posedge ref_clk) begin
      clock_stop_request_n <= !stop_want;
      sleep_request_n <= !(sleep_want && stop_want);
      deep_sleep_request_n <= !(deep_want && sleep_want && stop_want);
      sys_mgmt_irq_n <= !smi_want;
   end
endmodule

// File: dv/tb_cpu_power_state_control.sv
// Self-checking bench for the power state sequencer.
`timescale 1ns/1ns
module tb_cpu_power_state_control;
   import cps_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic stop_want = 1'b0, sleep_want = 1'b0, deep_want = 1'b0, smi_want = 1'b0;
   logic bus_clock_lost = 1'b0, snoop_req = 1'b0, intr_req = 1'b0, smm_resume = 1'b0;
   logic [7:0] junction_temp_c = 8'h19;
   logic clock_stop_request_n, sleep_request_n, deep_sleep_request_n, sys_mgmt_irq_n;
   cps_state_type power_state;
   cps_ack_type ack_code;
   logic [CLK_UNIT_W-1:0] unit_clk_en;
   logic pll_en, bus_clk_en, ack_valid, ack_oe, save_state, system_management_mode;
   logic handler_start, exec_run, snoop_ack, intr_ack, cache_invalidate;
   logic thermal_trip_out_n, thermal_trip_oe, outputs_oe;
   logic inval_seen = 1'b0;
   int failures = 0;
   int n_tests = 0;

   initial begin
      forever #5 ref_clk = !ref_clk;
   end
   // The invalidate pulse is short, so it is latched here and judged later.
   always @(posedge ref_clk) begin
      if (cache_invalidate === 1'b1) inval_seen <= 1'b1;
   end

   cps_platform_model platform (.ref_clk, .stop_want, .sleep_want, .deep_want,
      .smi_want, .clock_stop_request_n, .sleep_request_n, .deep_sleep_request_n,
      .sys_mgmt_irq_n);
   cps_power_ctrl dut (.ref_clk, .rst, .clock_stop_request_n, .sleep_request_n,
      .deep_sleep_request_n, .sys_mgmt_irq_n, .bus_clock_lost, .junction_temp_c,
      .snoop_req, .intr_req, .smm_resume, .power_state, .unit_clk_en, .pll_en,
      .bus_clk_en, .ack_code, .ack_valid, .ack_oe, .save_state,
      .system_management_mode, .handler_start, .exec_run, .snoop_ack, .intr_ack,
      .cache_invalidate, .thermal_trip_out_n, .thermal_trip_oe, .outputs_oe);

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic fin(input string nm);
      $display("test %s done, mismatches so far %0d", nm, failures);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Requests pass a synchroniser, so the wait is bounded rather than exact.
   task automatic wait_st(input cps_state_type s);
      for (int i = 0; i < 20 && power_state !== s; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("power_state", s, power_state);
   endtask
   task automatic do_reset(input logic exp_oe);
      @(posedge ref_clk);
      rst <= 1'b1;
      inval_seen <= 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      chk("outputs_oe", 0, outputs_oe);
      chk("power_state", ST_RUN, power_state);
      @(posedge ref_clk);
      rst <= 1'b0;
      tick(3);
      chk("cache_invalidate", 1, inval_seen);
      chk("outputs_oe", exp_oe, outputs_oe);
   endtask

   task automatic t_stop();
      @(posedge ref_clk);
      stop_want <= 1'b1;
      snoop_req <= 1'b1;
      intr_req <= 1'b1;
      wait_st(ST_STOP_GRANT);
      chk("ack_valid", 1, ack_valid);
      chk("ack_code", ACK_STOP_GRANT, ack_code);
      chk("unit_clk_en", 8'h03, unit_clk_en);
      chk("snoop_ack", 1, snoop_ack);
      chk("intr_ack", 1, intr_ack);
      chk("bus_clk_en", 1, bus_clk_en);
      tick(1);
      chk("ack_valid", 0, ack_valid);
      @(posedge ref_clk);
      stop_want <= 1'b0;
      wait_st(ST_RUN);
      chk("unit_clk_en", 8'h0F, unit_clk_en);
      chk("exec_run", 1, exec_run);
      fin("stop_clock");
   endtask
   task automatic t_sleep();
      @(posedge ref_clk);
      stop_want <= 1'b1;
      wait_st(ST_STOP_GRANT);
      @(posedge ref_clk);
      sleep_want <= 1'b1;
      wait_st(ST_SLEEP);
      chk("unit_clk_en", 0, unit_clk_en);
      chk("pll_en", 1, pll_en);
      chk("snoop_ack", 0, snoop_ack);
      chk("intr_ack", 0, intr_ack);
      @(posedge ref_clk);
      deep_want <= 1'b1;
      wait_st(ST_DEEP_SLEEP);
      chk("unit_clk_en", 0, unit_clk_en);
      @(posedge ref_clk);
      deep_want <= 1'b0;
      wait_st(ST_SLEEP);
      @(posedge ref_clk);
      bus_clock_lost <= 1'b1;
      wait_st(ST_DEEP_SLEEP);
      chk("unit_clk_en", 0, unit_clk_en);
      @(posedge ref_clk);
      bus_clock_lost <= 1'b0;
      wait_st(ST_SLEEP);
      @(posedge ref_clk);
      sleep_want <= 1'b0;
      wait_st(ST_STOP_GRANT);
      chk("ack_valid", 0, ack_valid);
      chk("bus clock", 1, unit_clk_en[UNIT_BUS]);
      @(posedge ref_clk);
      stop_want <= 1'b0;
      wait_st(ST_RUN);
      fin("sleep");
   endtask
   task automatic t_smi();
      @(posedge ref_clk);
      smi_want <= 1'b1;
      wait_st(ST_SMM);
      chk("save_state", 1, save_state);
      chk("system_management_mode", 1, system_management_mode);
      tick(1);
      chk("ack_valid", 1, ack_valid);
      chk("ack_code", ACK_SMI, ack_code);
      tick(1);
      chk("handler_start", 1, handler_start);
      @(posedge ref_clk);
      smi_want <= 1'b0;
      smm_resume <= 1'b1;
      wait_st(ST_RUN);
      @(posedge ref_clk);
      smm_resume <= 1'b0;
      fin("mgmt_irq");
   endtask
   task automatic t_therm();
      @(posedge ref_clk);
      junction_temp_c <= 8'h78;
      tick(4);
      chk("thermal_trip_out_n", 1, thermal_trip_out_n);
      @(posedge ref_clk);
      junction_temp_c <= 8'h79;
      wait_st(ST_HALT);
      chk("thermal_trip_out_n", 0, thermal_trip_out_n);
      chk("exec_run", 0, exec_run);
      chk("thermal_trip_oe", 1, thermal_trip_oe);
      @(posedge ref_clk);
      junction_temp_c <= 8'h19;
      do_reset(1'b1);
      chk("thermal_trip_out_n", 1, thermal_trip_out_n);
      fin("thermal");
   endtask
   task automatic t_smi_reset();
      @(posedge ref_clk);
      smi_want <= 1'b1;
      do_reset(1'b0);
      tick(4);
      chk("outputs_oe", 0, outputs_oe);
      chk("ack_oe", 0, ack_oe);
      @(posedge ref_clk);
      smi_want <= 1'b0;
      do_reset(1'b1);
      fin("mgmt_irq_at_reset");
   endtask

   // Whole run is about 130 cycles, so ten thousand is ample margin.
   initial begin
      #100000;
      failures++;
      complete_run();
   end
   initial begin
      do_reset(1'b1);
      t_stop();
      t_sleep();
      t_smi();
      t_therm();
      t_smi_reset();
      complete_run();
   end
endmodule
